// ---- rtl/clt_consts.vh ----
// Purpose: shared constants of the control/literal/table instruction core
// Assumes: included by its bare name
// Notes: register offsets are APB byte addresses
`ifndef CLT_CONSTS_VH
`define CLT_CONSTS_VH
// --------------------------------------------------
// Register offsets
// --------------------------------------------------
`define CLT_OFF_CTRL 12'h000
`define CLT_OFF_STATUS 12'h004
`define CLT_OFF_ACC 12'h008
`define CLT_OFF_PC 12'h00C
`define CLT_OFF_PROD 12'h010
`define CLT_OFF_TPTR 12'h014
`define CLT_OFF_TLAT 12'h018
`define CLT_OFF_PORT 12'h01C
`define CLT_OFF_PSET 12'h020
`define CLT_OFF_PCLR 12'h024
`define CLT_OFF_TMR 12'h028
`define CLT_OFF_PTR01 12'h02C
`define CLT_OFF_PTR2 12'h030
// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define CLT_CTRL_RUN 0
`define CLT_CTRL_PROG 1
`define CLT_CTRL_WAKE 2
`define CLT_CTRL_PSA 3
`define CLT_CTRL_MASK 4'hB
`define CLT_ST_C 0
`define CLT_ST_DC 1
`define CLT_ST_Z 2
`define CLT_ST_OV 3
`define CLT_ST_N 4
// --------------------------------------------------
// Reset values and timing
// --------------------------------------------------
`define CLT_RST_CTRL 4'h0
`define CLT_RST_FLAG_N 1'b1
`define CLT_TBLW_EXTRA 3'h3
`endif

// ---- rtl/clt_core.v ----
// Purpose: executes control-flow, literal and table instructions
// Assumes: PM_DATA_IN holds the word at PM_ADDR_OUT in the same cycle
// Notes: one instruction cycle per clock; registers reached over APB
// Behaviour
// - Conditional branch on flag, one/two cycles
// - Two-word absolute call with shadow flag
// - Two-word absolute jump, flags unchanged
// - Pop discards return stack top
// - Push saves address on return stack
// - Interrupt return re-enables irq, optional restore
// - Return loading literal into accumulator
// - Sleep and watchdog clear update flags
// - Add immediate updates all five flags
// - And/or/xor immediate update zero, negative
// - Load four bits into bank select
// - Load literal into accumulator
// - Multiply accumulator by literal, no flags
// - Subtract accumulator from literal, five flags
// - Two-word twelve-bit pointer load
// - Table read with pointer action, two cycles
// - Table write, two or five cycles
// - Taken branch, relative call and returns add a nop cycle
// - Stray second word runs as nop
// - Started internal write runs to completion
// - Port modify reads pin levels
// - Timer write clears assigned prescaler
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "clt_consts.vh"
module clt_core #(
	parameter STACK_DEPTH = 31,
	parameter SP_W = 5
) (
	input wire MCLK_IN, // Core clock, 20 MHz
	input wire RESET_IN, // Synchronous reset, high
	input wire PSEL_IN, // APB select
	input wire PENABLE_IN, // APB enable
	input wire PWRITE_IN, // APB direction
	input wire [11:0] PADDR_IN, // APB byte address
	input wire [31:0] PWDATA_IN, // APB write data
	output wire [31:0] PRDATA_OUT, // APB read data
	output wire PREADY_OUT, // APB ready
	output wire PSLVERR_OUT, // APB error
	output wire [19:0] PM_ADDR_OUT, // Fetch word address
	input wire [15:0] PM_DATA_IN, // Fetched word
	output wire [21:0] TBL_ADDR_OUT, // Table byte address
	input wire [7:0] TBL_RD_DATA_IN, // Table read byte
	output wire [7:0] TBL_WR_DATA_OUT, // Table write byte
	output wire TBL_WR_STB_OUT, // Table write strobe
	output wire TBL_PROG_OUT, // Internal write running
	output wire WDT_CLR_OUT, // Watchdog clear pulse
	output wire SLEEP_OUT, // Standby active
	input wire [7:0] PORT_PINS_IN, // Port pin levels
	output wire [7:0] PORT_OUT // Port output latch
);
	localparam S_EXEC = 3'h0;
	localparam S_SECOND = 3'h1;
	localparam S_FLUSH = 3'h2;
	localparam S_TBLR = 3'h3;
	localparam S_TBLP = 3'h4;
	localparam S_TBLW = 3'h5;
	localparam S_SLEEP = 3'h6;
	localparam [SP_W-1:0] STK_FULL = STACK_DEPTH[SP_W-1:0];

	reg [2:0] state_reg, state_next;
	reg [19:0] pc_reg, pc_next;
	reg [15:0] ir_reg, ir_next;
	reg [7:0] acc_reg, acc_next;
	reg [4:0] st_reg, st_next;
	reg [3:0] bank_select_reg, bank_select_next;
	reg [15:0] prod_reg, prod_next;
	reg [SP_W-1:0] sp_reg, sp_next;
	reg [21:0] tptr_reg, tptr_next;
	reg [7:0] tlat_reg, tlat_next;
	reg [1:0] tmode_reg, tmode_next;
	reg [2:0] cnt_reg, cnt_next;
	reg gie_reg, gie_next;
	reg peie_reg, peie_next;
	reg watchdog_expired_flag_n_reg, watchdog_expired_flag_n_next;
	reg powerdown_flag_n_reg, powerdown_flag_n_next;
	reg [7:0] sh_acc_reg, sh_acc_next;
	reg [4:0] sh_st_reg, sh_st_next;
	reg [3:0] sh_bank_reg, sh_bank_next;
	reg [3:0] ctrl_reg, ctrl_next;
	reg [7:0] port_reg, port_next;
	reg [7:0] timer_zero_reg, timer_zero_next;
	reg [7:0] presc_reg, presc_next;
	reg [31:0] prdata_reg;
	reg [7:0] pins_s1_reg, pins_s2_reg;
	reg [19:0] stack_mem [0:STACK_DEPTH-1];

	reg push_en, pop_en, ptr_ld, soft_rst, wdt_clr;
	reg [19:0] push_val, pc1;
	reg [1:0] ptr_sel;
	reg [11:0] ptr_val;
	reg [15:0] inst;
	reg [10:0] sum;
	reg [7:0] lg;
	reg [8:0] da1, da2;
	reg [31:0] rd_val;
	reg mapped;

	wire [35:0] ptr_all;
	wire [19:0] stack_top_entry;
	wire apb_wr, apb_setup, wake;
	reg cond_sel;
	wire cond_true;

	function [10:0] clt_add;
		input [7:0] a;
		input [7:0] b;
		input cin;
		reg [8:0] s;
		reg [4:0] h;
		begin
			s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			clt_add = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
		end
	endfunction

	assign stack_top_entry = (sp_reg == {SP_W{1'b0}}) ? 20'h00000 : stack_mem[sp_reg - 1'b1];
	assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign apb_setup = PSEL_IN & ~PENABLE_IN;
	assign wake = apb_wr && (PADDR_IN == `CLT_OFF_CTRL) && PWDATA_IN[`CLT_CTRL_WAKE];

	// --------------------------------------------------
	// Branch condition
	// --------------------------------------------------
	always @* begin
		case (PM_DATA_IN[10:9])
		2'h0: cond_sel = st_reg[`CLT_ST_Z];
		2'h1: cond_sel = st_reg[`CLT_ST_C];
		2'h2: cond_sel = st_reg[`CLT_ST_OV];
		default: cond_sel = st_reg[`CLT_ST_N];
		endcase
	end
	assign cond_true = cond_sel ^ PM_DATA_IN[8];

	// --------------------------------------------------
	// Instruction sequencing
	// --------------------------------------------------
	always @* begin
		state_next = state_reg;
		pc_next = pc_reg;
		ir_next = ir_reg;
		acc_next = acc_reg;
		st_next = st_reg;
		bank_select_next = bank_select_reg;
		prod_next = prod_reg;
		sp_next = sp_reg;
		tptr_next = tptr_reg;
		tlat_next = tlat_reg;
		tmode_next = tmode_reg;
		cnt_next = cnt_reg;
		gie_next = gie_reg;
		peie_next = peie_reg;
		watchdog_expired_flag_n_next = watchdog_expired_flag_n_reg;
		powerdown_flag_n_next = powerdown_flag_n_reg;
		sh_acc_next = sh_acc_reg;
		sh_st_next = sh_st_reg;
		sh_bank_next = sh_bank_reg;
		ctrl_next = ctrl_reg;
		port_next = port_reg;
		push_en = 1'b0;
		push_val = 20'h00000;
		pop_en = 1'b0;
		ptr_ld = 1'b0;
		ptr_sel = 2'h0;
		ptr_val = 12'h000;
		soft_rst = 1'b0;
		wdt_clr = 1'b0;
		pc1 = pc_reg + 20'h00001;
		inst = PM_DATA_IN;
		sum = 11'h000;
		lg = 8'h00;
		da1 = 9'h000;
		da2 = 9'h000;
		case (state_reg)
		S_EXEC: begin
			if (ctrl_reg[`CLT_CTRL_RUN]) begin
				pc_next = pc1;
				case (inst[15:12])
				4'hD: begin
					pc_next = pc1 + {{9{inst[10]}}, inst[10:0]};
					push_en = inst[11];
					push_val = pc1;
					state_next = S_FLUSH;
				end
				4'hE: begin
					if (!inst[11]) begin
						if (cond_true) begin
							pc_next = pc1 + {{12{inst[7]}}, inst[7:0]};
							state_next = S_FLUSH;
						end
					end else if (inst[10] && !(inst[9:8] == 2'h2 &&
						(inst[7:6] != 2'h0 || inst[5:4] == 2'h3))) begin
						ir_next = inst;
						state_next = S_SECOND;
					end
				end
				4'h0: begin
					if (inst[11:8] == 4'h0) begin
						casez (inst[7:0])
						8'h03: begin
							watchdog_expired_flag_n_next = 1'b1;
							powerdown_flag_n_next = 1'b0;
							wdt_clr = 1'b1;
							state_next = S_SLEEP;
						end
						8'h04: begin
							watchdog_expired_flag_n_next = 1'b1;
							powerdown_flag_n_next = 1'b1;
							wdt_clr = 1'b1;
						end
						8'h05: begin
							push_en = 1'b1;
							push_val = pc1;
						end
						8'h06: begin
							pop_en = 1'b1;
						end
						8'h07: begin
							da1 = {1'b0, acc_reg} +
								((acc_reg[3:0] > 4'h9 || st_reg[`CLT_ST_DC]) ? 9'h006 : 9'h000);
							da2 = da1 + ((da1[7:4] > 4'h9 || st_reg[`CLT_ST_C] || da1[8]) ?
								9'h060 : 9'h000);
							acc_next = da2[7:0];
							st_next[`CLT_ST_C] = st_reg[`CLT_ST_C] | da1[8] | da2[8];
						end
						8'b0000_1???: begin
							if (inst[1:0] == 2'h3)
								tptr_next = tptr_reg + 22'h000001;
							tmode_next = inst[1:0];
							state_next = inst[2] ? S_TBLP : S_TBLR;
						end
						8'b0001_00??: begin
							pc_next = stack_top_entry;
							pop_en = 1'b1;
							state_next = S_FLUSH;
							if (inst[0]) begin
								acc_next = sh_acc_reg;
								st_next = sh_st_reg;
								bank_select_next = sh_bank_reg;
							end
							if (!inst[1]) begin
								if (!gie_reg)
									gie_next = 1'b1;
								else
									peie_next = 1'b1;
							end
						end
						8'hFF: begin
							soft_rst = 1'b1;
						end
						default: begin
							pc_next = pc1;
						end
						endcase
					end else if (inst[11:4] == 8'h10) begin
						bank_select_next = inst[3:0];
					end else if (inst[11]) begin
						case (inst[10:8])
						3'h0: begin
							sum = clt_add(inst[7:0], ~acc_reg, 1'b1);
						end
						3'h7: begin
							sum = clt_add(inst[7:0], acc_reg, 1'b0);
						end
						3'h1: begin
							lg = acc_reg | inst[7:0];
						end
						3'h2: begin
							lg = acc_reg ^ inst[7:0];
						end
						3'h3: begin
							lg = acc_reg & inst[7:0];
						end
						3'h4: begin
							acc_next = inst[7:0];
							pc_next = stack_top_entry;
							pop_en = 1'b1;
							state_next = S_FLUSH;
						end
						3'h5: begin
							prod_next = acc_reg * inst[7:0];
						end
						default: begin
							acc_next = inst[7:0];
						end
						endcase
						if (inst[10:8] == 3'h0 || inst[10:8] == 3'h7) begin
							acc_next = sum[7:0];
							st_next = {sum[7], sum[10], sum[7:0] == 8'h00, sum[9], sum[8]};
						end
						if (inst[10:8] != 3'h0 && inst[10:8] < 3'h4) begin
							acc_next = lg;
							st_next[`CLT_ST_Z] = (lg == 8'h00);
							st_next[`CLT_ST_N] = lg[7];
						end
					end
				end
				default: begin
					pc_next = pc1;
				end
				endcase
			end
		end
		S_SECOND: begin
			state_next = S_EXEC;
			if (inst[15:12] == 4'hF) begin
				pc_next = pc1;
				case (ir_reg[9:8])
				2'h2: begin
					ptr_ld = 1'b1;
					ptr_sel = ir_reg[5:4];
					ptr_val = {ir_reg[3:0], inst[7:0]};
				end
				2'h3: begin
					pc_next = {inst[11:0], ir_reg[7:0]};
				end
				default: begin
					push_en = 1'b1;
					push_val = pc1;
					pc_next = {inst[11:0], ir_reg[7:0]};
					if (ir_reg[8]) begin
						sh_acc_next = acc_reg;
						sh_st_next = st_reg;
						sh_bank_next = bank_select_reg;
					end
				end
				endcase
			end
		end
		S_FLUSH: begin
			state_next = S_EXEC;
		end
		S_TBLR: begin
			tlat_next = TBL_RD_DATA_IN;
			if (tmode_reg == 2'h1)
				tptr_next = tptr_reg + 22'h000001;
			if (tmode_reg == 2'h2)
				tptr_next = tptr_reg - 22'h000001;
			state_next = S_EXEC;
		end
		S_TBLP: begin
			if (tmode_reg == 2'h1)
				tptr_next = tptr_reg + 22'h000001;
			if (tmode_reg == 2'h2)
				tptr_next = tptr_reg - 22'h000001;
			state_next = S_EXEC;
			if (ctrl_reg[`CLT_CTRL_PROG]) begin
				cnt_next = `CLT_TBLW_EXTRA;
				state_next = S_TBLW;
			end
		end
		S_TBLW: begin
			cnt_next = cnt_reg - 3'h1;
			if (cnt_reg == 3'h1)
				state_next = S_EXEC;
		end
		S_SLEEP: begin
			if (wake)
				state_next = S_EXEC;
		end
		default: begin
			state_next = S_EXEC;
		end
		endcase
		// Stack saturates rather than wrapping over live entries
		if (push_en && sp_reg != STK_FULL)
			sp_next = sp_reg + 1'b1;
		if (pop_en && sp_reg != {SP_W{1'b0}})
			sp_next = sp_reg - 1'b1;
		// Software writes win over the core in the same cycle
		if (apb_wr) begin
			case (PADDR_IN)
			`CLT_OFF_CTRL: ctrl_next = PWDATA_IN[3:0] & `CLT_CTRL_MASK;
			`CLT_OFF_TPTR: tptr_next = PWDATA_IN[21:0];
			`CLT_OFF_TLAT: tlat_next = PWDATA_IN[7:0];
			`CLT_OFF_PORT: port_next = PWDATA_IN[7:0];
			`CLT_OFF_PSET: port_next = pins_s2_reg | PWDATA_IN[7:0];
			`CLT_OFF_PCLR: port_next = pins_s2_reg & ~PWDATA_IN[7:0];
			default: ctrl_next = ctrl_reg;
			endcase
		end
	end

	// --------------------------------------------------
	// Timer zero and prescaler
	// --------------------------------------------------
	always @* begin
		timer_zero_next = timer_zero_reg + 8'h01;
		presc_next = presc_reg;
		if (ctrl_reg[`CLT_CTRL_PSA]) begin
			presc_next = presc_reg + 8'h01;
			if (presc_reg != 8'hFF)
				timer_zero_next = timer_zero_reg;
		end
		if (apb_wr && PADDR_IN == `CLT_OFF_TMR) begin
			timer_zero_next = PWDATA_IN[7:0];
			if (ctrl_reg[`CLT_CTRL_PSA])
				presc_next = 8'h00;
		end
	end

	// --------------------------------------------------
	// APB read decode
	// --------------------------------------------------
	always @* begin
		mapped = 1'b1;
		case (PADDR_IN)
		`CLT_OFF_CTRL: rd_val = {28'h0000000, ctrl_reg};
		`CLT_OFF_STATUS: rd_val = {20'h00000, state_reg, gie_reg, peie_reg,
			watchdog_expired_flag_n_reg, powerdown_flag_n_reg, st_reg};
		`CLT_OFF_ACC: rd_val = {20'h00000, bank_select_reg, acc_reg};
		`CLT_OFF_PC: rd_val = {{(12-SP_W){1'b0}}, sp_reg, pc_reg};
		`CLT_OFF_PROD: rd_val = {16'h0000, prod_reg};
		`CLT_OFF_TPTR: rd_val = {10'h000, tptr_reg};
		`CLT_OFF_TLAT: rd_val = {24'h000000, tlat_reg};
		`CLT_OFF_PORT: rd_val = {24'h000000, pins_s2_reg};
		`CLT_OFF_PSET: rd_val = 32'h00000000;
		`CLT_OFF_PCLR: rd_val = 32'h00000000;
		`CLT_OFF_TMR: rd_val = {16'h0000, presc_reg, timer_zero_reg};
		`CLT_OFF_PTR01: rd_val = {4'h0, ptr_all[23:12], 4'h0, ptr_all[11:0]};
		`CLT_OFF_PTR2: rd_val = {20'h00000, ptr_all[35:24]};
		default: begin
			rd_val = 32'h00000000;
			mapped = 1'b0;
		end
		endcase
	end

	// --------------------------------------------------
	// Indirect pointers
	// --------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_ptr
			reg [11:0] indirect_pointer_reg;
			always @(posedge MCLK_IN) begin
				if (RESET_IN || soft_rst)
					indirect_pointer_reg <= 12'h000;
				else if (ptr_ld && ptr_sel == gi)
					indirect_pointer_reg <= ptr_val;
			end
			assign ptr_all[gi*12 +: 12] = indirect_pointer_reg;
		end
	endgenerate

	// --------------------------------------------------
	// State registers
	// --------------------------------------------------
	always @(posedge MCLK_IN) begin
		if (push_en && sp_reg != STK_FULL)
			stack_mem[sp_reg] <= push_val;
		pins_s1_reg <= PORT_PINS_IN;
		pins_s2_reg <= pins_s1_reg;
		if (apb_setup && !PWRITE_IN)
			prdata_reg <= rd_val;
		if (RESET_IN)
			ctrl_reg <= `CLT_RST_CTRL;
		else
			ctrl_reg <= ctrl_next;
		// core state back to reset values
		if (RESET_IN || soft_rst) begin
			state_reg <= S_EXEC;
			pc_reg <= 20'h00000;
			ir_reg <= 16'h0000;
			acc_reg <= 8'h00;
			st_reg <= 5'h00;
			bank_select_reg <= 4'h0;
			prod_reg <= 16'h0000;
			sp_reg <= {SP_W{1'b0}};
			tptr_reg <= 22'h000000;
			tlat_reg <= 8'h00;
			tmode_reg <= 2'h0;
			cnt_reg <= 3'h0;
			gie_reg <= 1'b0;
			peie_reg <= 1'b0;
			watchdog_expired_flag_n_reg <= `CLT_RST_FLAG_N;
			powerdown_flag_n_reg <= `CLT_RST_FLAG_N;
			sh_acc_reg <= 8'h00;
			sh_st_reg <= 5'h00;
			sh_bank_reg <= 4'h0;
			port_reg <= 8'h00;
			timer_zero_reg <= 8'h00;
			presc_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			ir_reg <= ir_next;
			acc_reg <= acc_next;
			st_reg <= st_next;
			bank_select_reg <= bank_select_next;
			prod_reg <= prod_next;
			sp_reg <= sp_next;
			tptr_reg <= tptr_next;
			tlat_reg <= tlat_next;
			tmode_reg <= tmode_next;
			cnt_reg <= cnt_next;
			gie_reg <= gie_next;
			peie_reg <= peie_next;
			watchdog_expired_flag_n_reg <= watchdog_expired_flag_n_next;
			powerdown_flag_n_reg <= powerdown_flag_n_next;
			sh_acc_reg <= sh_acc_next;
			sh_st_reg <= sh_st_next;
			sh_bank_reg <= sh_bank_next;
			port_reg <= port_next;
			timer_zero_reg <= timer_zero_next;
			presc_reg <= presc_next;
		end
	end

	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
	assign PM_ADDR_OUT = pc_reg;
	assign TBL_ADDR_OUT = tptr_reg;
	assign TBL_WR_DATA_OUT = tlat_reg;
	assign TBL_WR_STB_OUT = (state_reg == S_TBLP);
	assign TBL_PROG_OUT = (state_reg == S_TBLW);
	assign WDT_CLR_OUT = wdt_clr;
	assign SLEEP_OUT = (state_reg == S_SLEEP);
	assign PORT_OUT = port_reg;
endmodule

// ---- verif/clt_core_checker.sv ----
// Purpose: port-level checks of the instruction core
// Assumes: bound to every clt_core instance
// Notes: core state is not visible, so checks lean on strobes and standby
`timescale 1ns/1ps
module clt_chk (
	input wire MCLK_IN, // Core clock
	input wire RESET_IN, // Sync reset
	input wire PSEL_IN, // APB select
	input wire PENABLE_IN, // APB enable
	input wire PSLVERR_OUT, // APB error
	input wire [19:0] PM_ADDR_OUT, // Fetch address
	input wire [15:0] PM_DATA_IN, // Fetched word
	input wire [21:0] TBL_ADDR_OUT, // Table address
	input wire TBL_WR_STB_OUT, // Table strobe
	input wire TBL_PROG_OUT, // Internal write
	input wire WDT_CLR_OUT, // Watchdog clear
	input wire SLEEP_OUT // Standby
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RESET_IN);
	// --------------------------------
	// Properties
	// --------------------------------
	property p_prog_len;
		$rose(TBL_PROG_OUT) |-> TBL_PROG_OUT [*3] ##1 !TBL_PROG_OUT;
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("internal write length wrong");
	property p_prog_src;
		$rose(TBL_PROG_OUT) |-> $past(TBL_WR_STB_OUT);
	endproperty
	a_prog_src: assert property (p_prog_src) else $error("internal write without strobe");
	property p_stb_pulse;
		TBL_WR_STB_OUT |=> !TBL_WR_STB_OUT;
	endproperty
	a_stb_pulse: assert property (p_stb_pulse) else $error("table strobe too long");
	property p_stb_excl;
		TBL_WR_STB_OUT |-> !TBL_PROG_OUT && !SLEEP_OUT;
	endproperty
	a_stb_excl: assert property (p_stb_excl) else $error("strobe during write or standby");
	property p_tbl_hold;
		TBL_PROG_OUT && $past(TBL_PROG_OUT) |-> $stable(TBL_ADDR_OUT);
	endproperty
	a_tbl_hold: assert property (p_tbl_hold) else $error("table address moved in write");
	property p_sleep_in;
		WDT_CLR_OUT && PM_DATA_IN == 16'h0003 |=> SLEEP_OUT;
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("standby not entered");
	property p_clr_step;
		WDT_CLR_OUT && PM_DATA_IN == 16'h0004 |=> PM_ADDR_OUT == $past(PM_ADDR_OUT) + 20'h00001;
	endproperty
	a_clr_step: assert property (p_clr_step) else $error("watchdog clear not one cycle");
	property p_sleep_hold;
		SLEEP_OUT |=> $stable(PM_ADDR_OUT);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("fetch moved in standby");
	property p_err;
		PSLVERR_OUT |-> PSEL_IN && PENABLE_IN;
	endproperty
	a_err: assert property (p_err) else $error("error outside access phase");
	c_sleep: cover property ($rose(SLEEP_OUT));
	c_prog: cover property ($rose(TBL_PROG_OUT));
	c_err: cover property (PSLVERR_OUT);
endmodule
bind clt_core clt_chk i_clt_chk (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PSLVERR_OUT(PSLVERR_OUT), .PM_ADDR_OUT(PM_ADDR_OUT),
	.PM_DATA_IN(PM_DATA_IN), .TBL_ADDR_OUT(TBL_ADDR_OUT), .TBL_WR_STB_OUT(TBL_WR_STB_OUT),
	.TBL_PROG_OUT(TBL_PROG_OUT), .WDT_CLR_OUT(WDT_CLR_OUT), .SLEEP_OUT(SLEEP_OUT));

// ---- verif/clt_core_test.sv ----
// Purpose: self-checking bench of the instruction core
// Assumes: program memory is a combinational array owned by the bench
// Notes: every program ends in standby, which halts the core for readback
`timescale 1ns/1ps
`include "clt_consts.vh"
module clt_core_test;
	reg clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rd, rv;
	reg [7:0] pins = 8'h00, a, b, dr, sd;
	reg [3:0] op, bk;
	reg [21:0] p, sadr;
	reg [12:0] e;
	reg [15:0] rom [0:63];
	integer errors = 0, check_count = 0, cyc, k0 = 0, tmo = 0, i, m, f;
	wire [31:0] prdata;
	wire [19:0] pma;
	wire [21:0] ta;
	wire [7:0] twd, pout;
	wire pready, pslverr, stb, prog, wdt, slp;
	function [7:0] tval(input [21:0] x);
		tval = x[7:0] ^ x[15:8] ^ x[21:16] ^ 8'h5A;
	endfunction
	function [12:0] alu(input [3:0] o, input [7:0] x, input [7:0] y);
		reg [8:0] r;
		reg c, dc, ov;
		begin
			c = 0; dc = 0; ov = 0; r = {1'b0, x};
			case (o)
			4'hF: begin r = x + y; c = r[8]; dc = (x[3:0] + y[3:0]) > 15;
				ov = (x[7] == y[7]) && (r[7] != x[7]); end
			4'h8: begin r = y - x; c = y >= x; dc = y[3:0] >= x[3:0];
				ov = (x[7] != y[7]) && (r[7] != y[7]); end
			4'hB: r = x & y;
			4'h9: r = x | y;
			4'hA: r = x ^ y;
			default: r = 9'h000;
			endcase
			if (o == 4'hD || o == 4'hE) alu = {5'h00, (o == 4'hE) ? y : x};
			else alu = {r[7], ov, r[7:0] == 8'h00, dc, c, r[7:0]};
		end
	endfunction
	clt_core i_clt_core (.MCLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PM_ADDR_OUT(pma),
		.PM_DATA_IN(rom[pma[5:0]]), .TBL_ADDR_OUT(ta), .TBL_RD_DATA_IN(tval(ta)),
		.TBL_WR_DATA_OUT(twd), .TBL_WR_STB_OUT(stb), .TBL_PROG_OUT(prog),
		.WDT_CLR_OUT(wdt), .SLEEP_OUT(slp), .PORT_PINS_IN(pins), .PORT_OUT(pout));
	always #25 clk = ~clk;
	// Hang guard and table strobe capture
	always @(posedge clk) begin
		tmo <= tmo + 1;
		if (stb === 1'b1) begin
			sadr <= ta;
			sd <= twd;
		end
		if (tmo == 20000) begin
			errors = errors + 1;
			stop_test;
		end
	end
	task chk(input [31:0] g, input [31:0] x);
		begin
			check_count = check_count + 1;
			if (g !== x) begin
				errors = errors + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
			end
		end
	endtask
	task apb(input w, input [11:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1; pwr <= w; paddr <= ad; pwdata <= d;
			@(posedge clk);
			pen <= 1;
			@(posedge clk);
			while (pready !== 1'b1) @(posedge clk);
			rd = prdata;
			err = pslverr;
			psel <= 0; pen <= 0;
		end
	endtask
	task rs;
		begin
			@(posedge clk);
			rst <= 1;
			repeat (2) @(posedge clk);
			rst <= 0;
		end
	endtask
	// Start the core, count cycles until standby
	task go(input [3:0] ctl);
		begin
			apb(1, `CLT_OFF_CTRL, {28'h0, ctl});
			cyc = 0;
			while (slp !== 1'b1 && cyc < 200) begin
				@(posedge clk);
				#1 cyc = cyc + 1;
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", check_count, errors);
			if (errors == 0 && check_count > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		for (i = 0; i < 64; i = i + 1) rom[i] = 16'h0000;
		rv = $urandom(32'he4aa);
		repeat (12) @(posedge clk);
		rst <= 0;
		// --------------------------------
		// Literal operations
		// --------------------------------
		for (i = 0; i < 21; i = i + 1) begin
			rv = $urandom;
			op = 28'hF8B9ADE >> (4 * (6 - i % 7));
			{bk, b, a} = (i < 7) ? {rv[3:0], 16'h01FF} : (i < 14) ? {rv[3:0], 16'h017F} : rv[19:0];
			rom[0] = {8'h0E, a}; rom[1] = {12'h010, bk}; rom[2] = {4'h0, op, b}; rom[3] = 16'h0003;
			rs;
			go(4'h1);
			e = alu(op, a, b);
			apb(0, `CLT_OFF_ACC, 0);
			chk(rd, {20'h0, bk, e[7:0]});
			apb(0, `CLT_OFF_STATUS, 0);
			chk(rd, 32'hC40 | e[12:8]);
			apb(0, `CLT_OFF_PROD, 0);
			if (op == 4'hD) chk(rd, a * b);
			apb(0, `CLT_OFF_PC, 0);
			chk(rd, 32'h4);
			chk(cyc - k0, 4);
		end
		$display("literal test done");
		// --------------------------------
		// Conditional branches over every condition
		// --------------------------------
		for (i = 0; i < 16; i = i + 1) begin
			rv = $urandom;
			{b, a} = rv[15:0];
			rom[0] = {8'h0E, a}; rom[1] = {8'h0F, b}; rom[2] = {5'h1C, i[2:0], 8'h01};
			rom[3] = 16'h0E11; rom[4] = 16'h0003;
			rs;
			go(4'h1);
			e = alu(4'hF, a, b);
			f = (i[2:1] == 0) ? e[10] : (i[2:1] == 1) ? e[8] : (i[2:1] == 2) ? e[11] : e[12];
			apb(0, `CLT_OFF_ACC, 0);
			chk(rd, ((f ^ i[0]) != 0) ? e[7:0] : 8'h11);
			chk(cyc - k0, 5);
		end
		$display("branch test done");
		// --------------------------------
		// Call, jump, return, stack, stray second word
		// --------------------------------
		rom[0] = 16'hEC10; rom[1] = 16'hF000; rom[2] = 16'hEF20; rom[3] = 16'hF000;
		rom[16] = 16'h0C5A; rom[32] = 16'hD001; rom[33] = 16'h0E11; rom[34] = 16'hD803;
		rom[35] = 16'hF123; rom[36] = 16'h0004; rom[37] = 16'h0003;
		rom[38] = 16'h0005; rom[39] = 16'h0006; rom[40] = 16'h0010;
		rs;
		go(4'h1);
		apb(0, `CLT_OFF_ACC, 0);
		chk(rd, 32'h5A);
		apb(0, `CLT_OFF_PC, 0);
		chk(rd, 32'h26);
		apb(0, `CLT_OFF_STATUS, 0);
		chk(rd, 32'hD40);
		chk(cyc - k0, 17);
		$display("control test done");
		// --------------------------------
		// Decimal adjust, shadow call, nested returns, soft reset
		// --------------------------------
		rom[0] = 16'h0E99; rom[1] = 16'h0F01; rom[2] = 16'h0007; rom[3] = 16'hED10;
		rom[4] = 16'hF000; rom[16] = 16'h0F77; rom[17] = 16'h0105; rom[18] = 16'h0013;
		rom[5] = 16'hD801; rom[6] = 16'h0003; rom[7] = 16'hD801; rom[8] = 16'h0010;
		rom[9] = 16'h0010;
		rs;
		go(4'h1);
		apb(0, `CLT_OFF_ACC, 0);
		chk(rd, 32'h0);
		apb(0, `CLT_OFF_STATUS, 0);
		chk(rd, 32'hDD1);
		apb(0, `CLT_OFF_PC, 0);
		chk(rd, 32'h7);
		chk(cyc - k0, 18);
		// Soft reset sends the core back to word 0, which then holds standby
		rom[0] = 16'h0E42; rom[1] = 16'h00FF;
		rs;
		apb(1, `CLT_OFF_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		rom[0] <= 16'h0003;
		repeat (3) @(posedge clk);
		apb(0, `CLT_OFF_ACC, 0);
		chk(rd, 32'h0);
		apb(0, `CLT_OFF_PC, 0);
		chk(rd, 32'h1);
		$display("shadow and reset test done");
		// --------------------------------
		// Pointer load and table modes
		// --------------------------------
		for (m = 0; m < 4; m = m + 1) begin
			rv = $urandom;
			f = (m == 3) ? 0 : m;
			rs;
			apb(1, `CLT_OFF_TPTR, {10'h0, rv[21:0]});
			rom[0] = {10'h3B8, f[1:0], rv[27:24]}; rom[1] = {8'hF0, rv[31:24]};
			rom[2] = 16'h0008 | m; rom[3] = 16'h000C | m; rom[4] = 16'h0003;
			go(m[0] ? 4'h3 : 4'h1);
			p = rv[21:0] + (m == 3);
			dr = tval(p);
			p = p + (m == 1) - (m == 2) + (m == 3);
			chk(sadr, p);
			chk(sd, dr);
			p = p + (m == 1) - (m == 2);
			apb(0, `CLT_OFF_TPTR, 0);
			chk(rd, p);
			apb(0, `CLT_OFF_TLAT, 0);
			chk(rd, dr);
			apb(0, (f == 2) ? `CLT_OFF_PTR2 : `CLT_OFF_PTR01, 0);
			chk(rd >> (f == 1 ? 16 : 0) & 32'hFFF, {rv[27:24], rv[31:24]});
			chk(cyc - k0, m[0] ? 10 : 7);
		end
		$display("table test done");
		// --------------------------------
		// Port read-modify-write, timer, unmapped access
		// --------------------------------
		rs;
		apb(1, `CLT_OFF_CTRL, 32'h8);
		repeat (100) @(posedge clk);
		rv = $urandom;
		apb(1, `CLT_OFF_TMR, rv[7:0]);
		apb(0, `CLT_OFF_TMR, 0);
		// Prescaler may have counted a few cycles since the write
		chk(rd & 32'hFFFFFCFF, rv[7:0]);
		for (i = 0; i < 4; i = i + 1) begin
			rv = $urandom;
			pins <= rv[7:0];
			apb(1, `CLT_OFF_PORT, ~rv[7:0]);
			repeat (3) @(posedge clk);
			apb(1, `CLT_OFF_PSET, rv[15:8]);
			@(posedge clk);
			#1 chk(pout, rv[7:0] | rv[15:8]);
			apb(1, `CLT_OFF_PCLR, rv[23:16]);
			@(posedge clk);
			#1 chk(pout, rv[7:0] & ~rv[23:16]);
		end
		apb(0, 12'h034, 0);
		chk(rd, 32'h0);
		chk(err, 1);
		apb(0, 12'h002, 0);
		chk(err, 1);
		$display("port test done");
		stop_test;
	end
endmodule
